// file: hdl/dwsc_consts.vh
// Constants for the dual wiper serial command unit
`ifndef DWSC_CONSTS_VH
`define DWSC_CONSTS_VH
`define DWSC_FRAME_BITS      24
`define DWSC_CMD_MSB         23
`define DWSC_CMD_LSB         20
`define DWSC_ADR_MSB         19
`define DWSC_ADR_LSB         16
`define DWSC_WIPER_BITS      10
`define DWSC_WIPER_MAX       10'h3FF
`define DWSC_MIDSCALE        16'h0200
`define DWSC_WIPER_MID       10'h200
`define DWSC_ADDR_FACTORY    4'hF
`define DWSC_USER_FIRST      4'h2
`define DWSC_USER_LAST       4'hE
`define DWSC_STORE_MS        15
`define DWSC_CLK_KHZ         125000
`define DWSC_STORE_CYCLES    (`DWSC_STORE_MS * `DWSC_CLK_KHZ)
`define DWSC_RDY_PULSE       5'h04
`define DWSC_CMD_NOP         4'h0
`define DWSC_CMD_RESTORE     4'h1
`define DWSC_CMD_SAVE_WIPER  4'h2
`define DWSC_CMD_SAVE_DATA   4'h3
`define DWSC_CMD_HALVE_ONE   4'h4
`define DWSC_CMD_HALVE_ALL   4'h5
`define DWSC_CMD_DEC_ONE     4'h6
`define DWSC_CMD_DEC_ALL     4'h7
`define DWSC_CMD_RELOAD_ALL  4'h8
`define DWSC_CMD_READ_NV     4'h9
`define DWSC_CMD_READ_WIPER  4'hA
`define DWSC_CMD_WRITE_WIPER 4'hB
`define DWSC_CMD_DOUBLE_ONE  4'hC
`define DWSC_CMD_DOUBLE_ALL  4'hD
`define DWSC_CMD_INC_ONE     4'hE
`define DWSC_CMD_INC_ALL     4'hF
`endif

// file: hdl/dwsc_sync.v
// Two flip-flop synchroniser for a bundle of asynchronous levels
module dwsc_sync #(
  parameter W = 4
) (
  input  wire         clk_i,
  input  wire         rst_n_i,
  input  wire [W-1:0] rst_val_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  // Reset value is a constant tie-off at the instance
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_ff <= rst_val_i;
      sync_ff <= rst_val_i;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end
  assign q_o = sync_ff;
endmodule // dwsc_sync

// file: hdl/dwsc_unit.v
// Serial command unit of a dual wiper nonvolatile potentiometer
// Behaviour
// (R1) 24-bit MSB-first frame: command, address, data
// (R2) Nonvolatile store takes about 15 ms
// (R3) Shift register locked during a store
// (R4) Ready pulses low when store completes
// (R5) Locations 2 to 14 are user words
// (R6) Commands 0-3: nop, restore, save wiper, save data
// (R7) Commands 4,5 halve; 12,13 double
// (R8) Commands 6,7 decrement; 14,15 increment
// (R9) Commands 9,10 read word or wiper out
// (R10) Command 11 writes data into wiper
// (R11) Command 8 reloads both wipers
// (R12) Zero code is terminal B; unlimited rewrites
// (R13) Power-on loads wipers; factory value midscale
// (R14) Preset low: midscale; high again: reload
// (R15) Write protect blocks all but restores; code also lets nop and reads 9,10 run
// (R16) Serial output released while select high
// (R17) Address bit 0 picks channel; 15 reserved
// (R18) Wiper takes 10 bits, words take 16
// (R19) Count clock edges; clear count unless multiple four
// (R20) Empty select pulse repeats last command
// (R21) Slave in mode 0 or mode 3
// (R22) Output echoes previous frame's word
// (R23) Execute when select returns high
// (R24) Address 0 is channel one, 1 channel two
// (R25) Halve and decrement stop at zero
// (R26) Ready also marks commands 2,3,8,9,10, preset
// (R27) Double and increment saturate at full scale
`include "dwsc_consts.vh"
module dwsc_unit #(
  parameter STORE_CYCLES = `DWSC_STORE_CYCLES
) (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       sclk_i,
  input  wire       cs_n_i,
  input  wire       sdi_i,
  input  wire       preset_strobe_n_i,
  input  wire       write_protect_n_i,
  output reg        sdo_o,
  output reg        sdo_oe_n_o,
  output reg        ready_o,
  output reg        ready_oe_n_o,
  output reg  [9:0] wiper_one_terminal_o,
  output reg  [9:0] wiper_two_terminal_o
);
  localparam ST_BOOT  = 2'h0;
  localparam ST_IDLE  = 2'h1;
  localparam ST_STORE = 2'h2;
  localparam ST_RDY   = 2'h3;

  wire [3:0] s;
  dwsc_sync #(.W(4)) u_sync (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .rst_val_i (4'hF),
    .d_i       ({sclk_i, cs_n_i, preset_strobe_n_i, write_protect_n_i}),
    .q_o       (s)
  );
  wire sclk_s = s[3];
  wire cs_s   = s[2];
  wire pr_s   = s[1];
  wire wp_s   = s[0];

  reg  [15:0] nonvolatile_word_store [0:15];
  reg  [9:0]  wiper_register [0:1];
  reg  [1:0]  state_ff;
  reg  [31:0] timer_ff;
  reg  [23:0] shift_ff;
  reg  [23:0] echo_ff;
  reg  [23:0] last_ff;
  reg  [4:0]  bits_ff;
  reg         seen_ff;
  reg         booted_ff;
  reg         sclk_d_ff;
  reg         cs_d_ff;
  reg         pr_d_ff;
  reg         sdi_ff;
  reg         sdi_ff2;
  reg  [3:0]  pend_adr_ff;
  reg  [15:0] pend_dat_ff;
  reg  [4:0]  rdy_cnt_ff;
  integer     i;

  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s & sclk_d_ff;
  wire cs_rise   = cs_s & ~cs_d_ff;
  wire cs_fall   = ~cs_s & cs_d_ff;
  wire pr_fall   = ~pr_s & pr_d_ff;
  wire pr_rise   = pr_s & ~pr_d_ff;

  function [9:0] halve;
    input [9:0] v;
    halve = v >> 1; // (R25)
  endfunction
  function [9:0] dbl;
    input [9:0] v;
    dbl = v[9] ? `DWSC_WIPER_MAX : {v[8:0], 1'b0}; // (R27)
  endfunction
  function [9:0] dec1;
    input [9:0] v;
    dec1 = (v == 10'h000) ? 10'h000 : v - 10'h001; // (R25)
  endfunction
  function [9:0] inc1;
    input [9:0] v;
    inc1 = (v == `DWSC_WIPER_MAX) ? v : v + 10'h001; // (R27)
  endfunction

  // Frame being executed: fresh bits, or a repeat on an empty pulse
  wire [23:0] frame = seen_ff ? shift_ff : last_ff; // (R20)
  wire [3:0]  cmd   = frame[`DWSC_CMD_MSB:`DWSC_CMD_LSB];
  wire [3:0]  adr   = frame[`DWSC_ADR_MSB:`DWSC_ADR_LSB];
  wire [15:0] dat   = frame[15:0];
  wire        ch    = adr[0]; // (R17) (R24)
  wire        mod_ok = wp_s; // (R15)
  wire        nv_ok  = (adr != `DWSC_ADDR_FACTORY); // (R17)
  wire        frame_ok = (bits_ff == 5'd0) & (seen_ff | booted_ff);

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff     <= ST_BOOT;
      timer_ff     <= 32'h0;
      shift_ff     <= 24'h0;
      echo_ff      <= 24'h0;
      last_ff      <= 24'h0;
      bits_ff      <= 5'h0;
      seen_ff      <= 1'b0;
      booted_ff    <= 1'b0;
      sclk_d_ff    <= 1'b1;
      cs_d_ff      <= 1'b1;
      pr_d_ff      <= 1'b1;
      sdi_ff       <= 1'b0;
      sdi_ff2      <= 1'b0;
      pend_adr_ff  <= 4'h0;
      pend_dat_ff  <= 16'h0;
      rdy_cnt_ff   <= 5'h0;
      sdo_o        <= 1'b1;
      sdo_oe_n_o   <= 1'b1;
      ready_o      <= 1'b1;
      ready_oe_n_o <= 1'b1;
      wiper_register[0] <= 10'h000;
      wiper_register[1] <= 10'h000;
      wiper_one_terminal_o <= 10'h000;
      wiper_two_terminal_o <= 10'h000;
      // Factory contents; a real array would keep them over reset
      for (i = 0; i < 16; i = i + 1)
        nonvolatile_word_store[i] <= `DWSC_MIDSCALE; // (R13)
    end else begin
      sclk_d_ff <= sclk_s;
      cs_d_ff   <= cs_s;
      pr_d_ff   <= pr_s;
      sdi_ff    <= sdi_i;
      sdi_ff2   <= sdi_ff;
      wiper_one_terminal_o <= wiper_register[0]; // (R12)
      wiper_two_terminal_o <= wiper_register[1];
      sdo_oe_n_o <= cs_s | sdo_o; // (R16)
      if (rdy_cnt_ff != 5'h0) begin
        rdy_cnt_ff <= rdy_cnt_ff - 5'h01;
        ready_oe_n_o <= 1'b0; // (R4) (R26)
        ready_o <= 1'b0;
      end else begin
        ready_oe_n_o <= 1'b1;
        ready_o <= 1'b1;
      end
      case (state_ff)
        ST_BOOT: begin
          wiper_register[0] <= nonvolatile_word_store[0][9:0]; // (R13)
          wiper_register[1] <= nonvolatile_word_store[1][9:0];
          state_ff <= ST_IDLE;
        end
        ST_STORE: begin
          // Serial edges are ignored here so the register stays locked
          if (timer_ff == 32'h0) begin // (R2) (R3)
            nonvolatile_word_store[pend_adr_ff] <= pend_dat_ff;
            rdy_cnt_ff <= `DWSC_RDY_PULSE; // (R4)
            state_ff <= ST_IDLE;
          end else begin
            timer_ff <= timer_ff - 32'h1;
          end
        end
        ST_IDLE: begin
          if (pr_fall) begin
            wiper_register[0] <= `DWSC_WIPER_MID; // (R14)
            wiper_register[1] <= `DWSC_WIPER_MID;
          end else if (pr_rise) begin
            wiper_register[0] <= nonvolatile_word_store[0][9:0]; // (R14)
            wiper_register[1] <= nonvolatile_word_store[1][9:0];
            rdy_cnt_ff <= `DWSC_RDY_PULSE; // (R26)
          end else if (cs_fall) begin
            seen_ff <= 1'b0;
            // Enable follows the new bit in the same cycle so the line never lags
            sdo_o      <= echo_ff[23]; // (R22)
            sdo_oe_n_o <= echo_ff[23]; // (R16)
          end else if (!cs_s && sclk_rise) begin
            // Sampling on the rising edge suits both mode 0 and mode 3
            shift_ff <= {shift_ff[22:0], sdi_ff2}; // (R1) (R21)
            seen_ff  <= 1'b1;
            bits_ff  <= (bits_ff == 5'd23) ? 5'd0 : bits_ff + 5'd1; // (R19)
            echo_ff  <= {echo_ff[22:0], 1'b1};
          end else if (!cs_s && sclk_fall) begin
            sdo_o      <= echo_ff[23]; // (R22)
            sdo_oe_n_o <= echo_ff[23]; // (R16)
          end else if (cs_rise) begin // (R23)
            sdo_o   <= 1'b1;
            seen_ff <= 1'b0;
            if (bits_ff[1:0] != 2'b00)
              bits_ff <= 5'd0; // (R19)
            if (frame_ok) begin
              booted_ff <= 1'b1;
              last_ff   <= frame;
              echo_ff   <= frame; // (R22)
              case (cmd) // (R6)
                `DWSC_CMD_NOP: ;
                `DWSC_CMD_RESTORE:
                  wiper_register[ch] <= nonvolatile_word_store[ch][9:0];
                `DWSC_CMD_SAVE_WIPER: if (mod_ok) begin
                  pend_adr_ff <= {3'h0, ch};
                  pend_dat_ff <= {6'h00, wiper_register[ch]};
                  timer_ff    <= STORE_CYCLES - 1; // (R2)
                  state_ff    <= ST_STORE;
                end
                `DWSC_CMD_SAVE_DATA: if (mod_ok && nv_ok) begin // (R5) (R18)
                  pend_adr_ff <= adr;
                  pend_dat_ff <= dat;
                  timer_ff    <= STORE_CYCLES - 1;
                  state_ff    <= ST_STORE;
                end
                `DWSC_CMD_HALVE_ONE: if (mod_ok)
                  wiper_register[ch] <= halve(wiper_register[ch]); // (R7)
                `DWSC_CMD_HALVE_ALL: if (mod_ok) begin
                  wiper_register[0] <= halve(wiper_register[0]);
                  wiper_register[1] <= halve(wiper_register[1]);
                end
                `DWSC_CMD_DEC_ONE: if (mod_ok)
                  wiper_register[ch] <= dec1(wiper_register[ch]); // (R8)
                `DWSC_CMD_DEC_ALL: if (mod_ok) begin
                  wiper_register[0] <= dec1(wiper_register[0]);
                  wiper_register[1] <= dec1(wiper_register[1]);
                end
                `DWSC_CMD_RELOAD_ALL: begin
                  wiper_register[0] <= nonvolatile_word_store[0][9:0]; // (R11)
                  wiper_register[1] <= nonvolatile_word_store[1][9:0];
                  rdy_cnt_ff <= `DWSC_RDY_PULSE; // (R26)
                end
                `DWSC_CMD_READ_NV: begin
                  echo_ff <= {frame[23:16], nv_ok ? nonvolatile_word_store[adr]
                                                 : 16'h0000}; // (R9)
                  rdy_cnt_ff <= `DWSC_RDY_PULSE;
                end
                `DWSC_CMD_READ_WIPER: begin
                  echo_ff <= {frame[23:16], 6'h00, wiper_register[ch]}; // (R9)
                  rdy_cnt_ff <= `DWSC_RDY_PULSE;
                end
                `DWSC_CMD_WRITE_WIPER: if (mod_ok)
                  wiper_register[ch] <= dat[9:0]; // (R10) (R18)
                `DWSC_CMD_DOUBLE_ONE: if (mod_ok)
                  wiper_register[ch] <= dbl(wiper_register[ch]); // (R7)
                `DWSC_CMD_DOUBLE_ALL: if (mod_ok) begin
                  wiper_register[0] <= dbl(wiper_register[0]);
                  wiper_register[1] <= dbl(wiper_register[1]);
                end
                `DWSC_CMD_INC_ONE: if (mod_ok)
                  wiper_register[ch] <= inc1(wiper_register[ch]); // (R8)
                default: if (mod_ok) begin
                  wiper_register[0] <= inc1(wiper_register[0]);
                  wiper_register[1] <= inc1(wiper_register[1]);
                end
              endcase
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule // dwsc_unit

// file: testbench/dwsc_unit_assertions.sv
// Port-level checks for the serial command unit
module dwsc_unit_assertions (
  input wire       clk_i,
  input wire       rst_n_i,
  input wire       cs_n_i,
  input wire       preset_strobe_n_i,
  input wire       sdo_oe_n_o,
  input wire       ready_o,
  input wire       ready_oe_n_o,
  input wire [9:0] wiper_one_terminal_o,
  input wire [9:0] wiper_two_terminal_o
);
  timeunit 1ns;
  timeprecision 100ps;
  wire rdy_p = !ready_oe_n_o && !ready_o;
  wire mid   = wiper_one_terminal_o == 10'h200 && wiper_two_terminal_o == 10'h200;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_pulse;
    rdy_p [*4] ##1 !rdy_p;
  endsequence
  // Select low long enough that any pending execution has landed
  sequence s_quiet;
    (!cs_n_i && preset_strobe_n_i) [*8];
  endsequence
  sdo_rel_a: assert property (cs_n_i [*5] |-> sdo_oe_n_o)
    else $error("serial output driven while deselected");
  frame_start_a: assert property (cs_n_i [*5] ##1 !cs_n_i |-> sdo_oe_n_o [*2])
    else $error("serial output driven before select was synchronised");
  rdy_len_a: assert property ($rose(rdy_p) |-> s_pulse)
    else $error("ready pulse length wrong");
  rdy_od_a: assert property (!ready_oe_n_o |-> !ready_o)
    else $error("ready driven high");
  wiper_hold_a: assert property (s_quiet |-> $stable(wiper_one_terminal_o)
    && $stable(wiper_two_terminal_o)) else $error("wiper moved inside a frame");
  preset_mid_a: assert property (!preset_strobe_n_i [*6] |-> mid)
    else $error("preset low but wipers not midscale");
  preset_rdy_a: assert property ($rose(preset_strobe_n_i) |-> ##[2:10] rdy_p)
    else $error("no ready pulse after preset");
  boot_mid_a: assert property ($rose(rst_n_i) |-> ##[1:3] mid)
    else $error("wipers not loaded at power on");
endmodule // dwsc_unit_assertions

bind dwsc_unit dwsc_unit_assertions u_dwsc_unit_assertions (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .preset_strobe_n_i(preset_strobe_n_i),
  .sdo_oe_n_o(sdo_oe_n_o), .ready_o(ready_o), .ready_oe_n_o(ready_oe_n_o),
  .wiper_one_terminal_o(wiper_one_terminal_o), .wiper_two_terminal_o(wiper_two_terminal_o));

// file: testbench/dwsc_host.sv
// Serial host model: mode 0 frames, 80 ns link clock
module dwsc_host (
  input  logic clk_i,
  input  logic sdo_o,
  input  logic sdo_oe_n_o,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_o = 0;
    cs_n_o = 1;
    sdi_o = 0;
  end
  task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rx);
    rx = 24'h000000;
    @(posedge clk_i);
    #1 cs_n_o = 0;
    #40;
    for (int k = 0; k < n; k++) begin
      sdi_o = w[23-k];
      #20 sclk_o = 1;
      // Pull-up makes the released line read high
      rx = {rx[22:0], sdo_oe_n_o | sdo_o};
      #40 sclk_o = 0;
      #20;
    end
    @(posedge clk_i);
    #1 cs_n_o = 1;
    sdi_o = ~sdi_o;
    repeat (12) @(posedge clk_i);
  endtask
endmodule // dwsc_host

// file: testbench/dwsc_unit_tb_top.sv
// Self-checking bench for the serial command unit
module dwsc_unit_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i, rst_n_i, preset_n, wp_n, sclk, cs_n, sdi, sdo, sdo_oe_n, rdy, rdy_oe_n;
  logic [9:0]  w1, w2;
  logic [23:0] rx, prev;
  int          n_mismatch, checks_done;
  // Frame, expected wiper one, expected wiper two
  logic [47:0] rows [17] = '{48'hB00100_100_200, 48'hB103FF_100_3FF, 48'hE10000_100_3FF,
    48'hC00000_200_3FF, 48'hF00000_201_3FF, 48'hD00000_3FF_3FF, 48'h500000_1FF_1FF,
    48'h400000_0FF_1FF, 48'hB00001_001_1FF, 48'h600000_000_1FF, 48'h600000_000_1FF,
    48'h410000_000_0FF, 48'h700000_000_0FE, 48'hB0FC05_005_0FE, 48'h000000_005_0FE,
    48'h110000_005_200, 48'h800000_200_200};
  dwsc_unit #(.STORE_CYCLES(600)) u_dwsc_unit (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .preset_strobe_n_i(preset_n), .write_protect_n_i(wp_n), .sdo_o(sdo),
    .sdo_oe_n_o(sdo_oe_n), .ready_o(rdy), .ready_oe_n_o(rdy_oe_n),
    .wiper_one_terminal_o(w1), .wiper_two_terminal_o(w2));
  dwsc_host u_dwsc_host (.clk_i(clk_i), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
    .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
  initial begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Outputs are looked at mid-cycle, away from the edge that launches them
  task automatic cw(input logic [9:0] a, input logic [9:0] b);
    @(negedge clk_i);
    chk({4'h0, w1, w2}, {4'h0, a, b});
    @(posedge clk_i);
  endtask
  task automatic wait_rdy;
    int i;
    for (i = 0; i < 1000 && !(rdy_oe_n === 1'b0 && rdy === 1'b0); i++) @(negedge clk_i);
    chk({23'h0, i < 1000}, 24'h000001);
    repeat (6) @(posedge clk_i);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    rst_n_i = 0;
    preset_n = 1;
    wp_n = 1;
    n_mismatch = 0;
    checks_done = 0;
    prev = 24'h000000;
    repeat (12) @(posedge clk_i);
    #1 rst_n_i = 1;
    repeat (8) @(posedge clk_i);
    cw(10'h200, 10'h200);
    chk({23'h0, sdo_oe_n}, 24'h000001);
    foreach (rows[i]) begin
      u_dwsc_host.xfer(rows[i][47:24], 24, rx);
      if (i > 0) chk(rx, prev);
      prev = rows[i][47:24];
      cw(rows[i][21:12], rows[i][9:0]);
    end
    u_dwsc_host.xfer(24'hA00000, 24, rx);
    u_dwsc_host.xfer(24'h000000, 24, rx);
    chk(rx, 24'hA00200);
    u_dwsc_host.xfer(24'hB00155, 24, rx);
    u_dwsc_host.xfer(24'h200000, 24, rx);
    u_dwsc_host.xfer(24'hB003FF, 24, rx);
    wait_rdy;
    cw(10'h155, 10'h200);
    u_dwsc_host.xfer(24'hB00000, 24, rx);
    u_dwsc_host.xfer(24'h100000, 24, rx);
    cw(10'h155, 10'h200);
    u_dwsc_host.xfer(24'h35BEEF, 24, rx);
    wait_rdy;
    u_dwsc_host.xfer(24'h3FAAAA, 24, rx);
    u_dwsc_host.xfer(24'h950000, 24, rx);
    u_dwsc_host.xfer(24'h9F0000, 24, rx);
    chk(rx, 24'h95BEEF);
    u_dwsc_host.xfer(24'h000000, 24, rx);
    chk(rx, 24'h9F0000);
    u_dwsc_host.xfer(24'hB00077, 24, rx);
    u_dwsc_host.xfer(24'hB00123, 21, rx);
    cw(10'h077, 10'h200);
    u_dwsc_host.xfer(24'hE00000, 24, rx);
    u_dwsc_host.xfer(24'h000000, 0, rx);
    cw(10'h079, 10'h200);
    #1 wp_n = 0;
    u_dwsc_host.xfer(24'hB00300, 24, rx);
    cw(10'h079, 10'h200);
    u_dwsc_host.xfer(24'h100000, 24, rx);
    cw(10'h155, 10'h200);
    #1 wp_n = 1;
    preset_n = 0;
    repeat (10) @(posedge clk_i);
    cw(10'h200, 10'h200);
    #1 preset_n = 1;
    wait_rdy;
    cw(10'h155, 10'h200);
    #1 rst_n_i = 0;
    repeat (3) @(posedge clk_i);
    #1 rst_n_i = 1;
    repeat (4) @(posedge clk_i);
    cw(10'h200, 10'h200);
    end_of_test;
  end
endmodule // dwsc_unit_tb_top
